// ==== hdl/periph_regs_pkg.sv ====
package periph_regs_pkg;

  // apb byte addresses, one aligned word each
  localparam logic [7:0] OFS_MAIN_CTRL = 8'h00;
  localparam logic [7:0] OFS_PIE       = 8'h04;
  localparam logic [7:0] OFS_PIR       = 8'h08;
  localparam logic [7:0] OFS_POWER_CONTROL_STATUS      = 8'h0C;
  localparam logic [7:0] OFS_APF       = 8'h10;
  localparam logic [7:0] OFS_EVT_STS   = 8'h14;
  localparam logic [7:0] OFS_EVT_CLR   = 8'h18;
  localparam logic [7:0] OFS_EVT_EN    = 8'h1C;

  // main interrupt control fields
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_GATE_BIT = 6;
  localparam logic [7:0] MAIN_CTRL_MASK = 8'hC0;

  // enable / request / event layout
  localparam int ADC_BIT    = 6;
  localparam int CAPCMP_BIT = 5;
  localparam int CMP_BIT    = 3;
  localparam int TMR2_BIT   = 1;
  localparam int TIMER_ONE_BIT   = 0;
  localparam int BROWN_BIT  = 7;
  localparam logic [7:0] IMPL_FULL    = 8'h6B;
  localparam logic [7:0] IMPL_REDUCED = 8'h09;

  // power control fields
  localparam int POR_BIT = 1;
  localparam int BOR_BIT = 0;
  localparam logic [7:0] POWER_CONTROL_STATUS_MASK = 8'h03;

  // pin steering fields and pin slots
  localparam int GATE_SEL_BIT = 4;
  localparam int PWM2_SEL_BIT = 1;
  localparam int PWM1_SEL_BIT = 0;
  localparam logic [7:0] APF_MASK = 8'h13;
  localparam int PIN_0 = 0;
  localparam int PIN_2 = 1;
  localparam int PIN_4 = 2;
  localparam int PIN_5 = 3;

  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // capture/compare unit modes
  typedef enum logic [1:0] {MODE_CAPTURE, MODE_COMPARE, MODE_PWM, MODE_OFF} capcmp_mode_t;

  typedef enum {SEL_MAIN, SEL_PIE, SEL_PIR, SEL_POWER_CONTROL_STATUS, SEL_APF,
                SEL_STS, SEL_CLR, SEL_EN, SEL_NONE} reg_sel_t;

  typedef struct packed {
    logic [7:0]  main_ctrl;
    logic [7:0]  pie;
    logic [7:0]  pir;
    logic [7:0]  power_control_status;
    logic [7:0]  apf;
    logic [7:0]  evt_sts;
    logic [7:0]  evt_en;
    logic [1:0]  gp3_s;
    logic [1:0]  gp4_s;
    logic [1:0]  boren_s;
    logic [1:0]  bordet_s;
    logic        bordet_prev;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
    logic        periph_irq;
    logic        gate_in;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe;
  } state_t;

  // address decode, shared by write and read paths
  function automatic reg_sel_t decode(input logic [7:0] addr);
    case (addr)
      OFS_MAIN_CTRL: decode = SEL_MAIN;
      OFS_PIE:       decode = SEL_PIE;
      OFS_PIR:       decode = SEL_PIR;
      OFS_POWER_CONTROL_STATUS:      decode = SEL_POWER_CONTROL_STATUS;
      OFS_APF:       decode = SEL_APF;
      OFS_EVT_STS:   decode = SEL_STS;
      OFS_EVT_CLR:   decode = SEL_CLR;
      OFS_EVT_EN:    decode = SEL_EN;
      default:       decode = SEL_NONE;
    endcase
  endfunction : decode

endpackage : periph_regs_pkg

// ==== hdl/periph_irq_reset_pinsel_regs.sv ====
// Functional notes
// R1: peripheral gate bit must allow peripheral interrupts
// R2: per-source enables at bits 6,5,3,1,0
// R3: reduced variant hides adc, capcmp, timer-two bits
// R4: flags set regardless of any enable
// R5: software clears flag before enabling source
// R6: hardware sets flags; software clears them
// R7: capcmp flag on capture or compare, not pwm
// R8: power-on status reads 0 after reset
// R9: brown-out status 0 after brownout or disabled
// R10: steering bit 4 picks timer gate pin
// R11: steering bit 1 picks second pwm pin
// R12: steering bit 0 picks first pwm pin
// R13: global enable blocks every interrupt when clear; the code gates only periph_irq with it, not irq
// R14: request is gated OR of enabled flags
// R15: hardware set beats same-cycle software clear
`timescale 1ns/1ps
module periph_irq_reset_pinsel_regs #(
  parameter logic FULL_VARIANT = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        adc_done,
  input  wire logic        capcmp_capture,
  input  wire logic        capcmp_match,
  input  wire logic [1:0]  capcmp_mode,
  input  wire logic        comparator_change,
  input  wire logic        timer_two_match,
  input  wire logic        timer_one_overflow,
  input  wire logic        bor_enable,
  input  wire logic        bor_detect,
  input  wire logic        general_pin_3_in,
  input  wire logic        general_pin_4_in,
  input  wire logic        pwm_first_output,
  input  wire logic        pwm_second_output,
  output logic             timer_one_gate_input,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe,
  output logic             periph_irq,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // state and bus phase decode

  periph_regs_pkg::state_t     s_q;
  periph_regs_pkg::state_t     s_d;
  periph_regs_pkg::reg_sel_t   sel;
  logic                        rd_phase;
  logic                        wr_now;
  logic                        wr_pir;
  logic                        bor_fall;
  logic [7:0]                  impl;
  logic [7:0]                  hw_set;
  logic [7:0]                  pir_wr;

  assign sel      = periph_regs_pkg::decode(paddr);
  // first access cycle loads read data; the second commits the write
  assign rd_phase = psel && penable && !s_q.pready;
  assign wr_now   = psel && penable && s_q.pready && pwrite;
  assign wr_pir   = wr_now && (sel == periph_regs_pkg::SEL_PIR);
  // detector edge, taken after the synchroniser only
  assign bor_fall = s_q.bordet_s[1] && !s_q.bordet_prev;
  assign impl     = FULL_VARIANT ? periph_regs_pkg::IMPL_FULL
                                 : periph_regs_pkg::IMPL_REDUCED;   // [R3]

  ////////////////////////////////////////////////////////////////////////////////
  // hardware event sources, independent of every enable

  always_comb begin
    hw_set = periph_regs_pkg::RESET_BYTE;
    hw_set[periph_regs_pkg::ADC_BIT]  = adc_done;                   // [R6]
    hw_set[periph_regs_pkg::CAPCMP_BIT] =                           // [R7]
      (capcmp_mode == periph_regs_pkg::MODE_CAPTURE && capcmp_capture) ||
      (capcmp_mode == periph_regs_pkg::MODE_COMPARE && capcmp_match);
    hw_set[periph_regs_pkg::CMP_BIT]  = comparator_change;          // [R6]
    hw_set[periph_regs_pkg::TMR2_BIT] = timer_two_match;            // [R6]
    hw_set[periph_regs_pkg::TIMER_ONE_BIT] = timer_one_overflow;         // [R4]
    hw_set = hw_set & impl;                                         // [R3]
    pir_wr = wr_pir ? pwdata[7:0] : s_q.pir;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    s_d = s_q;
    // two-flop synchronisers for pins and detector levels
    s_d.gp3_s    = {s_q.gp3_s[0], general_pin_3_in};
    s_d.gp4_s    = {s_q.gp4_s[0], general_pin_4_in};
    s_d.boren_s  = {s_q.boren_s[0], bor_enable};
    s_d.bordet_s = {s_q.bordet_s[0], bor_detect};
    s_d.bordet_prev = s_q.bordet_s[1];

    // software writes land on the edge that sees pready high
    if (wr_now) begin
      case (sel)
        periph_regs_pkg::SEL_MAIN:
          s_d.main_ctrl = pwdata[7:0] & periph_regs_pkg::MAIN_CTRL_MASK;
        periph_regs_pkg::SEL_PIE: s_d.pie = pwdata[7:0] & impl;    // [R2] [R3]
        periph_regs_pkg::SEL_POWER_CONTROL_STATUS:
          s_d.power_control_status = pwdata[7:0] & periph_regs_pkg::POWER_CONTROL_STATUS_MASK;     // [R8] [R9]
        periph_regs_pkg::SEL_APF:
          s_d.apf = pwdata[7:0] & periph_regs_pkg::APF_MASK;       // [R12]
        periph_regs_pkg::SEL_EN: s_d.evt_en = pwdata[7:0];
        default: s_d.power_control_status = s_q.power_control_status;
      endcase
    end

    // request flags: a write stores, a hardware set always wins
    s_d.pir = (pir_wr | hw_set) & impl;                             // [R15] [R6]

    // brown-out clears its status bit until software sets it again
    if (bor_fall) begin
      s_d.power_control_status[periph_regs_pkg::BOR_BIT] = 1'b0;                    // [R9]
    end

    // sticky event status, write-one-to-clear, set beats clear
    s_d.evt_sts = s_q.evt_sts;
    if (wr_now && sel == periph_regs_pkg::SEL_CLR) begin
      s_d.evt_sts = s_q.evt_sts & ~pwdata[7:0];
    end
    s_d.evt_sts = s_d.evt_sts | hw_set;
    s_d.evt_sts[periph_regs_pkg::BROWN_BIT] = s_d.evt_sts[periph_regs_pkg::BROWN_BIT] | bor_fall;
    s_d.irq = |(s_d.evt_sts & s_d.evt_en);

    // core request: gated by peripheral gate and global enable
    s_d.periph_irq = s_d.main_ctrl[periph_regs_pkg::GLOBAL_EN_BIT] &&   // [R13]
                     s_d.main_ctrl[periph_regs_pkg::PERIPH_GATE_BIT] && // [R1]
                     |(s_d.pir & s_d.pie);                              // [R14]

    // timer gate input from pin 3 or pin 4
    s_d.gate_in = s_q.apf[periph_regs_pkg::GATE_SEL_BIT] ? s_q.gp3_s[1]
                                                         : s_q.gp4_s[1];  // [R10]

    // pwm steering; a pin not chosen is released
    s_d.pin_oe  = 4'h0;
    s_d.pin_out = 4'h0;
    if (s_q.apf[periph_regs_pkg::PWM2_SEL_BIT]) begin                // [R11]
      s_d.pin_oe[periph_regs_pkg::PIN_4]  = 1'b1;
      s_d.pin_out[periph_regs_pkg::PIN_4] = pwm_second_output;
    end else begin
      s_d.pin_oe[periph_regs_pkg::PIN_0]  = 1'b1;
      s_d.pin_out[periph_regs_pkg::PIN_0] = pwm_second_output;
    end
    if (s_q.apf[periph_regs_pkg::PWM1_SEL_BIT]) begin                // [R12]
      s_d.pin_oe[periph_regs_pkg::PIN_5]  = 1'b1;
      s_d.pin_out[periph_regs_pkg::PIN_5] = pwm_first_output;
    end else begin
      s_d.pin_oe[periph_regs_pkg::PIN_2]  = 1'b1;
      s_d.pin_out[periph_regs_pkg::PIN_2] = pwm_first_output;
    end

    // apb answer: one wait state, then pready for one cycle
    s_d.pready  = rd_phase;
    s_d.pslverr = rd_phase && sel == periph_regs_pkg::SEL_NONE;
    if (rd_phase) begin
      case (sel)
        periph_regs_pkg::SEL_MAIN: s_d.prdata = {24'h00_0000, s_q.main_ctrl};
        periph_regs_pkg::SEL_PIE:  s_d.prdata = {24'h00_0000, s_q.pie & impl};
        periph_regs_pkg::SEL_PIR:  s_d.prdata = {24'h00_0000, s_q.pir & impl};
        periph_regs_pkg::SEL_POWER_CONTROL_STATUS: begin
          // brown-out status is hidden while the detector is off
          s_d.prdata = {24'h00_0000, s_q.power_control_status};
          s_d.prdata[periph_regs_pkg::BOR_BIT] =
            s_q.power_control_status[periph_regs_pkg::BOR_BIT] && s_q.boren_s[1];     // [R9]
        end
        periph_regs_pkg::SEL_APF:  s_d.prdata = {24'h00_0000, s_q.apf};
        periph_regs_pkg::SEL_STS:  s_d.prdata = {24'h00_0000, s_q.evt_sts};
        periph_regs_pkg::SEL_EN:   s_d.prdata = {24'h00_0000, s_q.evt_en};
        default:                   s_d.prdata = periph_regs_pkg::RESET_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; reset leaves power-on status at 0

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;                                                     // [R8]
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata               = s_q.prdata;
  assign pready               = s_q.pready;
  assign pslverr              = s_q.pslverr;
  assign timer_one_gate_input = s_q.gate_in;
  assign pin_out              = s_q.pin_out;
  assign pin_oe               = s_q.pin_oe;
  assign periph_irq           = s_q.periph_irq;
  assign irq                  = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_gate_blocks: assert property ( // [R1]
    periph_irq |-> s_q.main_ctrl[periph_regs_pkg::PERIPH_GATE_BIT])
    else $error("peripheral request without gate bit");

  chk_global_blocks: assert property ( // [R13]
    !s_q.main_ctrl[periph_regs_pkg::GLOBAL_EN_BIT] |-> !periph_irq)
    else $error("peripheral request with global enable clear");

  chk_request_or: assert property ( // [R14]
    periph_irq == (s_q.main_ctrl[periph_regs_pkg::GLOBAL_EN_BIT] &&
                   s_q.main_ctrl[periph_regs_pkg::PERIPH_GATE_BIT] &&
                   |(s_q.pir & s_q.pie)))
    else $error("peripheral request does not match flags");

  chk_flag_set: assert property ( // [R4]
    (timer_one_overflow || comparator_change) ##1 1'b1 |->
      s_q.pir[periph_regs_pkg::TIMER_ONE_BIT] == $past(timer_one_overflow) ||
      $past(timer_one_overflow) == 1'b0)
    else $error("timer one flag missed");

  chk_adc_flag: assert property ( // [R6]
    FULL_VARIANT && adc_done |=> s_q.pir[periph_regs_pkg::ADC_BIT])
    else $error("adc flag missed");

  chk_capcmp_flag: assert property ( // [R7]
    (capcmp_mode == periph_regs_pkg::MODE_PWM && !wr_pir &&
     !s_q.pir[periph_regs_pkg::CAPCMP_BIT]) |=>
      !s_q.pir[periph_regs_pkg::CAPCMP_BIT])
    else $error("capcmp flag set in pwm mode");

  chk_reduced_zero: assert property ( // [R3]
    !FULL_VARIANT |-> ((s_q.pir | s_q.pie) & ~periph_regs_pkg::IMPL_REDUCED) == 8'h00)
    else $error("reduced variant bit set");

  chk_bor_hidden: assert property ( // [R9]
    (rd_phase && sel == periph_regs_pkg::SEL_POWER_CONTROL_STATUS && !s_q.boren_s[1]) |=>
      !prdata[periph_regs_pkg::BOR_BIT])
    else $error("brown-out status visible while disabled");

  chk_gate_route: assert property ( // [R10]
    ##1 timer_one_gate_input == ($past(s_q.apf[periph_regs_pkg::GATE_SEL_BIT]) ?
                                 $past(s_q.gp3_s[1]) : $past(s_q.gp4_s[1])))
    else $error("timer gate taken from wrong pin");

  chk_pwm_route: assert property ( // [R12]
    s_q.apf[periph_regs_pkg::PWM1_SEL_BIT] && !wr_now |=>
      pin_oe[periph_regs_pkg::PIN_5] && !pin_oe[periph_regs_pkg::PIN_2])
    else $error("first pwm on wrong pin");

  chk_pwm2_route: assert property ( // [R11]
    !s_q.apf[periph_regs_pkg::PWM2_SEL_BIT] && !wr_now |=>
      pin_oe[periph_regs_pkg::PIN_0] && !pin_oe[periph_regs_pkg::PIN_4])
    else $error("second pwm on wrong pin");

  chk_set_wins: assert property ( // [R15]
    wr_pir && !pwdata[periph_regs_pkg::TIMER_ONE_BIT] && timer_one_overflow |=>
      s_q.pir[periph_regs_pkg::TIMER_ONE_BIT])
    else $error("hardware set lost to software clear");

endmodule : periph_irq_reset_pinsel_regs

// ==== verification/event_source_model.sv ====
`timescale 1ns/1ps
module event_source_model (
  input  wire logic       clk,
  input  wire logic [5:0] fire,
  output logic            adc_done,
  output logic            capcmp_capture,
  output logic            capcmp_match,
  output logic            comparator_change,
  output logic            timer_two_match,
  output logic            timer_one_overflow
);
  // registered strobes; each event follows its fire bit one clock later and lasts as long as that bit is held
  always_ff @(posedge clk) begin
    {adc_done, capcmp_match, capcmp_capture} <= fire[5:3];
    {comparator_change, timer_two_match, timer_one_overflow} <= fire[2:0];
  end
endmodule : event_source_model

// ==== verification/periph_irq_reset_pinsel_regs_bench.sv ====
`timescale 1ns/1ps
module periph_irq_reset_pinsel_regs_bench;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, x, v;
  logic [1:0]  capcmp_mode;
  logic        bor_enable, bor_detect, general_pin_3_in, general_pin_4_in;
  logic        pwm_first_output, pwm_second_output, timer_one_gate_input, periph_irq, irq;
  logic [3:0]  pin_out, pin_oe;
  logic [5:0]  fire;
  logic        adc_done, capcmp_capture, capcmp_match;
  logic        comparator_change, timer_two_match, timer_one_overflow;
  logic [7:0]  ebit [6] = '{8'h01, 8'h02, 8'h08, 8'h20, 8'h20, 8'h40};
  int          err_count, num_checks;

  event_source_model src (.clk, .fire, .adc_done, .capcmp_capture, .capcmp_match,
    .comparator_change, .timer_two_match, .timer_one_overflow);
  periph_irq_reset_pinsel_regs DUT (.clk, .resetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .adc_done, .capcmp_capture, .capcmp_match,
    .capcmp_mode, .comparator_change, .timer_two_match, .timer_one_overflow, .bor_enable,
    .bor_detect, .general_pin_3_in, .general_pin_4_in, .pwm_first_output,
    .pwm_second_output, .timer_one_gate_input, .pin_out, .pin_oe, .periph_irq, .irq);

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // xorshift keeps the run repeatable without simulator seeds
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; request held until pready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      $display("BAD %0t no pready", $time);
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk

  // strobe events through the far-side model, then let flags settle
  task automatic pulse(logic [5:0] m);
    @(posedge clk);
    fire <= m;
    @(posedge clk);
    fire <= 6'h00;
    repeat (3) @(posedge clk);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, psel, penable, pwrite, bor_enable, bor_detect} = 6'h00;
    {general_pin_3_in, general_pin_4_in, pwm_first_output, pwm_second_output} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    capcmp_mode = 2'h0;
    fire = 6'h00;
    x = 32'h0000_ab81;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    // reset values, then an unmapped word
    for (int a = 0; a < 8; a++) rdchk(8'(a * 4), 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    $display("test reset done");
    // random writes; unimplemented positions must read back zero
    repeat (6) begin
      v = rnd();
      apb(1'b1, periph_regs_pkg::OFS_PIE, v);
      rdchk(periph_regs_pkg::OFS_PIE, v & periph_regs_pkg::IMPL_FULL);
      apb(1'b1, periph_regs_pkg::OFS_PIR, v);
      rdchk(periph_regs_pkg::OFS_PIR, v & periph_regs_pkg::IMPL_FULL);
    end
    $display("test registers done");
    // every source with all enables off; capcmp in capture then compare mode
    apb(1'b1, periph_regs_pkg::OFS_PIE, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      capcmp_mode <= (i == 4) ? 2'h1 : 2'h0;
      apb(1'b1, periph_regs_pkg::OFS_PIR, 32'h0000_0000);
      pulse(6'(1 << i));
      rdchk(periph_regs_pkg::OFS_PIR, ebit[i]);
    end
    capcmp_mode <= 2'h2;
    apb(1'b1, periph_regs_pkg::OFS_PIR, 32'h0000_0000);
    pulse(6'h18);
    rdchk(periph_regs_pkg::OFS_PIR, 32'h0000_0000);
    $display("test flags done");
    // pending comparator flag under all four gate settings
    apb(1'b1, periph_regs_pkg::OFS_PIE, 32'h0000_0008);
    pulse(6'h04);
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, periph_regs_pkg::OFS_MAIN_CTRL, 32'(g << 6));
      repeat (2) @(posedge clk);
      check(periph_irq, g == 3);
    end
    apb(1'b1, periph_regs_pkg::OFS_PIE, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check(periph_irq, 1'b0);
    $display("test gating done");
    // brown-out event, masking and clearing of the event interrupt
    bor_enable <= 1'b1;
    apb(1'b1, periph_regs_pkg::OFS_POWER_CONTROL_STATUS, 32'h0000_0003);
    rdchk(periph_regs_pkg::OFS_POWER_CONTROL_STATUS, 32'h0000_0003);
    apb(1'b1, periph_regs_pkg::OFS_EVT_EN, 32'h0000_0080);
    bor_detect <= 1'b1;
    repeat (8) @(posedge clk);
    bor_detect <= 1'b0;
    rdchk(periph_regs_pkg::OFS_POWER_CONTROL_STATUS, 32'h0000_0002);
    check(irq, 1'b1);
    // earlier flag tests left their event bits set; clear them all first
    apb(1'b1, periph_regs_pkg::OFS_EVT_CLR, 32'h0000_00ff);
    apb(1'b1, periph_regs_pkg::OFS_EVT_EN, 32'h0000_0000);
    pulse(6'h01);
    rdchk(periph_regs_pkg::OFS_EVT_STS, 32'h0000_0001);
    check(irq, 1'b0);
    apb(1'b1, periph_regs_pkg::OFS_EVT_EN, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    apb(1'b1, periph_regs_pkg::OFS_EVT_CLR, 32'h0000_0001);
    apb(1'b1, periph_regs_pkg::OFS_EVT_STS, 32'h0000_00ff);
    rdchk(periph_regs_pkg::OFS_EVT_STS, 32'h0000_0000);
    check(irq, 1'b0);
    // brown-out status hidden while disabled, cleared by a second reset
    apb(1'b1, periph_regs_pkg::OFS_POWER_CONTROL_STATUS, 32'h0000_0003);
    bor_enable <= 1'b0;
    repeat (4) @(posedge clk);
    rdchk(periph_regs_pkg::OFS_POWER_CONTROL_STATUS, 32'h0000_0002);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rdchk(periph_regs_pkg::OFS_POWER_CONTROL_STATUS, 32'h0000_0000);
    $display("test power done");
    // random steering with random pwm and pin levels
    repeat (8) begin
      v = rnd();
      {pwm_second_output, pwm_first_output} <= v[9:8];
      {general_pin_4_in, general_pin_3_in} <= v[11:10];
      apb(1'b1, periph_regs_pkg::OFS_APF, v);
      repeat (5) @(posedge clk);
      rdchk(periph_regs_pkg::OFS_APF, v & periph_regs_pkg::APF_MASK);
      check(pin_oe, {v[0], v[1], ~v[0], ~v[1]});
      check(pin_out, {v[0] & v[8], v[1] & v[9], ~v[0] & v[8], ~v[1] & v[9]});
      check(timer_one_gate_input, v[4] ? v[10] : v[11]);
    end
    $display("test steering done");
    finish_test();
  end
endmodule : periph_irq_reset_pinsel_regs_bench
